// >>> ctt_pkg.sv
// Shared constants and types for the transfer and test execution unit.
// Assumes one 250 MHz clock and a synchronous active-high reset.
package ctt_pkg;

    localparam int AM_W = 36;

    // Opcodes
    localparam logic [15:0] OPC_TST_X8  = 16'h0006;
    localparam logic [15:0] OPC_TST_Y8  = 16'h0016;
    localparam logic [15:0] OPC_TST_Z8  = 16'h0026;
    localparam logic [15:0] OPC_TST_X16 = 16'h1706;
    localparam logic [15:0] OPC_TST_Y16 = 16'h1716;
    localparam logic [15:0] OPC_TST_Z16 = 16'h1726;
    localparam logic [15:0] OPC_TST_EXT = 16'h1736;
    localparam logic [15:0] OPC_TEST_ACC_A_OP    = 16'h3706;
    localparam logic [15:0] OPC_TEST_ACC_B_OP    = 16'h3716;
    localparam logic [15:0] OPC_TEST_ACC_D_OP    = 16'h27f6;
    localparam logic [15:0] OPC_TEST_ACC_E_OP    = 16'h2776;
    localparam logic [15:0] OPC_LDWED   = 16'h27b1;
    localparam logic [15:0] OPC_LDWE    = 16'h27b2;
    localparam logic [15:0] OPC_WIDX    = 16'h27b3;
    localparam logic [15:0] OPC_WER     = 16'h27b4;
    localparam logic [15:0] OPC_WET     = 16'h27b5;
    localparam logic [15:0] OPC_DMSK    = 16'h372f;
    localparam logic [15:0] OPC_EXTB    = 16'h27bb;
    localparam logic [15:0] OPC_SEXTB   = 16'h37af;
    localparam logic [15:0] OPC_BXK     = 16'h379c;
    localparam logic [15:0] OPC_BYK     = 16'h379d;
    localparam logic [15:0] OPC_BZK     = 16'h379e;
    localparam logic [15:0] OPC_BSK     = 16'h379f;
    localparam logic [15:0] OPC_DE      = 16'h277b;
    localparam logic [15:0] OPC_ED      = 16'h27fb;
    localparam logic [15:0] OPC_FLGA    = 16'h37fc;
    localparam logic [15:0] OPC_FLGD    = 16'h372c;
    localparam logic [15:0] OPC_DFLG    = 16'h372d;

    // Cycle counts
    localparam logic [3:0] CYC_2 = 4'd2;
    localparam logic [3:0] CYC_4 = 4'd4;
    localparam logic [3:0] CYC_6 = 4'd6;

    // Register offsets
    localparam logic [3:0] REG_D     = 4'h0;
    localparam logic [3:0] REG_E     = 4'h1;
    localparam logic [3:0] REG_IX    = 4'h2;
    localparam logic [3:0] REG_CCR   = 4'h3;
    localparam logic [3:0] REG_AM_LO = 4'h4;
    localparam logic [3:0] REG_AM_MI = 4'h5;
    localparam logic [3:0] REG_AM_HI = 4'h6;
    localparam logic [3:0] REG_XYZS  = 4'h7;
    localparam logic [3:0] REG_EK    = 4'h8;
    localparam logic [3:0] REG_MASK  = 4'h9;
    localparam logic [3:0] REG_STAT  = 4'ha;

    // Flag positions in the condition code register
    localparam int CCR_MV = 14;
    localparam int CCR_EV = 12;
    localparam int CCR_N  = 11;
    localparam int CCR_Z  = 10;
    localparam int CCR_V  = 9;
    localparam int CCR_C  = 8;
    localparam int CCR_SM = 4;

    // Reset values
    localparam logic [15:0]   RST_W16 = 16'h0000;
    localparam logic [15:0]   RST_CCR = 16'h0000;
    localparam logic [AM_W-1:0] RST_AM = '0;
    localparam logic [3:0]    RST_X4  = 4'h0;
    localparam logic [7:0]    RST_MSK = 8'h00;

    // Rounding and saturation constants
    localparam logic [AM_W:0] RND_HALF = 37'h0_0000_8000;
    localparam logic [15:0]   SAT_POS  = 16'h7fff;
    localparam logic [15:0]   SAT_NEG  = 16'h8000;

    typedef struct packed {
        logic [15:0] opcode;
        logic [15:0] operand;
    } ctt_req_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } ctt_state_t;

endpackage

// >>> ctt_wide_sat.sv
// Rounding and saturation of the wide accumulator into a 16-bit word.
// Assumes the caller supplies the live overflow flags and saturation bit.
`timescale 1ns/10ps
module ctt_wide_sat
    import ctt_pkg::*;
(
    input  wire logic [AM_W-1:0] am_i,
    input  wire logic            round_i,
    input  wire logic            sm_i,
    input  wire logic            ev_i,
    input  wire logic            mv_i,
    output logic      [15:0]     word_o,
    output logic                 ev_o,
    output logic                 mv_o
);
    logic [AM_W:0]   tmp;
    logic [AM_W-1:0] src;

    // Round by adding half an upper-word step
    assign tmp = {am_i[AM_W-1], am_i} + RND_HALF;
    assign src = round_i ? tmp[AM_W-1:0] : am_i;

    // Overflow flags: new ones after rounding, held ones otherwise
    assign mv_o = round_i ? (tmp[AM_W] ^ tmp[AM_W-1]) : mv_i;
    assign ev_o = round_i ? ~((&src[AM_W-1:31]) | ~(|src[AM_W-1:31])) : ev_i;

    // Saturate toward the sign of the unrounded value
    always_comb begin
        if (sm_i && (ev_o || mv_o)) begin
            word_o = am_i[AM_W-1] ? SAT_NEG : SAT_POS;
        end else begin
            word_o = src[31:16];
        end
    end
endmodule

// >>> ctt_exec.sv
// Execution unit for the transfer and test instruction group.
// Assumes one instruction is issued at a time with a valid/ready handshake,
// and software reaches the registers over a simple strobe port.
// Functional notes
// - Memory byte test sets N,Z; clears V,C
// - Test A/B in two cycles
// - Test D/E word in two cycles
// - Load wide from E:D, sign extend
// - Load wide from E, low zeroed
// - Rounded wide to E with saturation
// - Truncated wide to E with saturation
// - Spread wide across IX, E, D
// - D bytes into X and Y masks
// - Extended field into B low nibble
// - Stack field into B low nibble
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module ctt_exec
    import ctt_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    input  wire logic              op_valid_i,
    input  wire ctt_req_t          op_req_i,
    output logic                   op_ready_o,
    output logic                   op_done_o,
    output logic                   op_illegal_o,
    input  wire logic [ADDR_W-1:0] reg_addr_i,
    input  wire logic [15:0]       reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic      [15:0]       reg_rdata_o
);

    // Refuse address widths that cannot reach the map
    if (ADDR_W < 4) begin : g_chk
        $error("ctt_exec needs ADDR_W of at least 4");
    end

    ctt_state_t      state_ff;
    logic [3:0]      cnt_ff;
    logic [15:0]     d_ff;
    logic [15:0]     e_ff;
    logic [15:0]     ix_ff;
    logic [15:0]     ccr_ff;
    logic [AM_W-1:0] am_ff;
    logic [3:0]      ext_ff [4];
    logic [3:0]      ek_ff;
    logic [7:0]      xmsk_ff;
    logic [7:0]      ymsk_ff;
    logic            ill_ff;
    logic            ill_sticky_ff;
    logic [15:0]     rdata_ff;

    logic [15:0]     nxt_d;
    logic [15:0]     nxt_e;
    logic [15:0]     nxt_ix;
    logic [15:0]     nxt_ccr;
    logic [AM_W-1:0] nxt_am;
    logic [3:0]      nxt_ext [4];
    logic [3:0]      nxt_ek;
    logic [7:0]      nxt_xmsk;
    logic [7:0]      nxt_ymsk;
    logic            nxt_ill;
    logic [15:0]     nxt_rdata;

    logic            accept;
    logic            bus_wr;
    logic [3:0]      cyc;
    logic [15:0]     sat_word;
    logic            sat_ev;
    logic            sat_mv;

    // Cycle count of an opcode; zero marks an unknown opcode
    function automatic logic [3:0] op_cycles(input logic [15:0] opc);
        case (opc)
            OPC_TST_X8, OPC_TST_Y8, OPC_TST_Z8,
            OPC_TST_X16, OPC_TST_Y16, OPC_TST_Z16,
            OPC_TST_EXT:                 op_cycles = CYC_6;
            OPC_TEST_ACC_A_OP, OPC_TEST_ACC_B_OP:          op_cycles = CYC_2;
            OPC_TEST_ACC_D_OP, OPC_TEST_ACC_E_OP:          op_cycles = CYC_2;
            OPC_LDWED:                   op_cycles = CYC_4;
            OPC_LDWE:                    op_cycles = CYC_4;
            OPC_WER:                     op_cycles = CYC_6;
            OPC_WET:                     op_cycles = CYC_2;
            OPC_WIDX:                    op_cycles = CYC_6;
            OPC_DMSK:                    op_cycles = CYC_2;
            OPC_EXTB:                    op_cycles = CYC_2;
            OPC_SEXTB:                   op_cycles = CYC_2;
            OPC_BXK, OPC_BYK, OPC_BZK,
            OPC_BSK, OPC_DE, OPC_ED,
            OPC_FLGA, OPC_FLGD:          op_cycles = CYC_2;
            OPC_DFLG:                    op_cycles = CYC_4;
            default:                     op_cycles = 4'd0;
        endcase
    endfunction

    // Update N and Z, optionally clearing V and C
    function automatic logic [15:0] set_nz(input logic [15:0] condition_code_reg,
                                           input logic        neg,
                                           input logic        zero,
                                           input logic        clr_v,
                                           input logic        clr_c);
        set_nz        = condition_code_reg;
        set_nz[CCR_N] = neg;
        set_nz[CCR_Z] = zero;
        if (clr_v) begin
            set_nz[CCR_V] = 1'b0;
        end
        if (clr_c) begin
            set_nz[CCR_C] = 1'b0;
        end
    endfunction

    // Handshake: accept only when idle; done in the last busy cycle
    assign op_ready_o = (state_ff == ST_IDLE);
    assign accept     = op_valid_i && op_ready_o;
    assign op_done_o  = (state_ff == ST_BUSY) && (cnt_ff == 4'd1);
    assign cyc        = op_cycles(op_req_i.opcode);

    // Software writes are refused while an instruction owns the registers
    assign bus_wr = reg_wr_i && op_ready_o && !accept;

    // Rounding and saturation path for the wide-to-E moves
    ctt_wide_sat u_sat (
        .am_i    (am_ff),
        .round_i (op_req_i.opcode == OPC_WER),
        .sm_i    (ccr_ff[CCR_SM]),
        .ev_i    (ccr_ff[CCR_EV]),
        .mv_i    (ccr_ff[CCR_MV]),
        .word_o  (sat_word),
        .ev_o    (sat_ev),
        .mv_o    (sat_mv)
    );

    // Sequencer state
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= 4'd0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (accept) begin
                        state_ff <= ST_BUSY;
                        cnt_ff   <= (cyc == 4'd0) ? (CYC_2 - 4'd1) : (cyc - 4'd1);
                    end
                end
                ST_BUSY: begin
                    cnt_ff <= cnt_ff - 4'd1;
                    if (cnt_ff == 4'd1) begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                    cnt_ff   <= 4'd0;
                end
            endcase
        end
    end

    // Instruction results and software writes
    always_comb begin
        nxt_d    = d_ff;
        nxt_e    = e_ff;
        nxt_ix   = ix_ff;
        nxt_ccr  = ccr_ff;
        nxt_am   = am_ff;
        nxt_ek   = ek_ff;
        nxt_xmsk = xmsk_ff;
        nxt_ymsk = ymsk_ff;
        nxt_ill  = ill_ff;
        for (int i = 0; i < 4; i++) begin
            nxt_ext[i] = ext_ff[i];
        end
        if (accept) begin
            nxt_ill = (cyc == 4'd0);
            case (op_req_i.opcode)
                OPC_TST_X8, OPC_TST_Y8, OPC_TST_Z8,
                OPC_TST_X16, OPC_TST_Y16, OPC_TST_Z16,
                OPC_TST_EXT: begin
                    nxt_ccr = set_nz(ccr_ff, op_req_i.operand[7],
                                     op_req_i.operand[7:0] == 8'h00,
                                     1'b1, 1'b1);
                end
                OPC_TEST_ACC_A_OP: begin
                    nxt_ccr = set_nz(ccr_ff, d_ff[15], d_ff[15:8] == 8'h00,
                                     1'b1, 1'b1);
                end
                OPC_TEST_ACC_B_OP: begin
                    nxt_ccr = set_nz(ccr_ff, d_ff[7], d_ff[7:0] == 8'h00,
                                     1'b1, 1'b1);
                end
                OPC_TEST_ACC_D_OP: begin
                    nxt_ccr = set_nz(ccr_ff, d_ff[15], d_ff == 16'h0000,
                                     1'b1, 1'b1);
                end
                OPC_TEST_ACC_E_OP: begin
                    nxt_ccr = set_nz(ccr_ff, e_ff[15], e_ff == 16'h0000,
                                     1'b1, 1'b1);
                end
                OPC_LDWED: begin
                    nxt_am          = {{4{e_ff[15]}}, e_ff, d_ff};
                    nxt_ccr[CCR_MV] = 1'b0;
                    nxt_ccr[CCR_EV] = 1'b0;
                end
                OPC_LDWE: begin
                    nxt_am          = {{4{e_ff[15]}}, e_ff, 16'h0000};
                    nxt_ccr[CCR_MV] = 1'b0;
                    nxt_ccr[CCR_EV] = 1'b0;
                end
                OPC_WER: begin
                    nxt_e           = sat_word;
                    nxt_ccr         = set_nz(ccr_ff, sat_word[15],
                                             sat_word == 16'h0000,
                                             1'b0, 1'b0);
                    nxt_ccr[CCR_MV] = sat_mv;
                    nxt_ccr[CCR_EV] = sat_ev;
                end
                OPC_WET: begin
                    nxt_e   = sat_word;
                    nxt_ccr = set_nz(ccr_ff, sat_word[15],
                                     sat_word == 16'h0000, 1'b0, 1'b0);
                end
                OPC_WIDX: begin
                    nxt_ix = {{12{am_ff[35]}}, am_ff[35:32]};
                    nxt_e  = am_ff[31:16];
                    nxt_d  = am_ff[15:0];
                end
                OPC_DMSK: begin
                    nxt_xmsk = d_ff[15:8];
                    nxt_ymsk = d_ff[7:0];
                end
                OPC_EXTB: begin
                    nxt_d[7:0] = {4'h0, ek_ff};
                end
                OPC_SEXTB: begin
                    nxt_d[7:0] = {4'h0, ext_ff[3]};
                end
                OPC_BXK, OPC_BYK, OPC_BZK, OPC_BSK: begin
                    nxt_ext[op_req_i.opcode[1:0]] = d_ff[3:0];
                end
                OPC_DE: begin
                    nxt_e   = d_ff;
                    nxt_ccr = set_nz(ccr_ff, d_ff[15], d_ff == 16'h0000,
                                     1'b1, 1'b0);
                end
                OPC_ED: begin
                    nxt_d   = e_ff;
                    nxt_ccr = set_nz(ccr_ff, e_ff[15], e_ff == 16'h0000,
                                     1'b1, 1'b0);
                end
                OPC_FLGA: begin
                    nxt_d[15:8] = ccr_ff[15:8];
                end
                OPC_FLGD: begin
                    nxt_d = ccr_ff;
                end
                OPC_DFLG: begin
                    nxt_ccr[15:4] = d_ff[15:4];
                end
                default: begin
                    nxt_d = d_ff;
                end
            endcase
        end else if (bus_wr) begin
            case (reg_addr_i[3:0])
                REG_D:     nxt_d          = reg_wdata_i;
                REG_E:     nxt_e          = reg_wdata_i;
                REG_IX:    nxt_ix         = reg_wdata_i;
                REG_CCR:   nxt_ccr        = reg_wdata_i;
                REG_AM_LO: nxt_am[15:0]   = reg_wdata_i;
                REG_AM_MI: nxt_am[31:16]  = reg_wdata_i;
                REG_AM_HI: nxt_am[35:32]  = reg_wdata_i[3:0];
                REG_XYZS: begin
                    for (int i = 0; i < 4; i++) begin
                        nxt_ext[i] = reg_wdata_i[4*i +: 4];
                    end
                end
                REG_EK:    nxt_ek         = reg_wdata_i[3:0];
                REG_MASK: begin
                    nxt_xmsk = reg_wdata_i[15:8];
                    nxt_ymsk = reg_wdata_i[7:0];
                end
                default:   nxt_d          = d_ff;
            endcase
        end
    end

    // Accumulators and index register
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            d_ff  <= RST_W16;
            e_ff  <= RST_W16;
            ix_ff <= RST_W16;
        end else begin
            d_ff  <= nxt_d;
            e_ff  <= nxt_e;
            ix_ff <= nxt_ix;
        end
    end

    // Condition codes and wide accumulator
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ccr_ff <= RST_CCR;
            am_ff  <= RST_AM;
        end else begin
            ccr_ff <= nxt_ccr;
            am_ff  <= nxt_am;
        end
    end

    // Address extension fields X, Y, Z and stack
    for (genvar g = 0; g < 4; g++) begin : g_ext
        always_ff @(posedge sys_clk_i) begin
            if (rst_i) begin
                ext_ff[g] <= RST_X4;
            end else begin
                ext_ff[g] <= nxt_ext[g];
            end
        end
    end

    // Extended field and modulo masks
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ek_ff   <= RST_X4;
            xmsk_ff <= RST_MSK;
            ymsk_ff <= RST_MSK;
        end else begin
            ek_ff   <= nxt_ek;
            xmsk_ff <= nxt_xmsk;
            ymsk_ff <= nxt_ymsk;
        end
    end

    // Illegal opcode: per instruction level plus a sticky copy
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ill_ff        <= 1'b0;
            ill_sticky_ff <= 1'b0;
        end else begin
            ill_ff <= nxt_ill;
            if (accept && (cyc == 4'd0)) begin
                ill_sticky_ff <= 1'b1;  // Set wins over the clear
            end else if (bus_wr && (reg_addr_i[3:0] == REG_STAT)
                         && reg_wdata_i[1]) begin
                ill_sticky_ff <= 1'b0;
            end
        end
    end

    assign op_illegal_o = ill_ff;

    // Read multiplexer
    always_comb begin
        case (reg_addr_i[3:0])
            REG_D:     nxt_rdata = d_ff;
            REG_E:     nxt_rdata = e_ff;
            REG_IX:    nxt_rdata = ix_ff;
            REG_CCR:   nxt_rdata = ccr_ff;
            REG_AM_LO: nxt_rdata = am_ff[15:0];
            REG_AM_MI: nxt_rdata = am_ff[31:16];
            REG_AM_HI: nxt_rdata = {12'h000, am_ff[35:32]};
            REG_XYZS:  nxt_rdata = {ext_ff[3], ext_ff[2], ext_ff[1], ext_ff[0]};
            REG_EK:    nxt_rdata = {12'h000, ek_ff};
            REG_MASK:  nxt_rdata = {xmsk_ff, ymsk_ff};
            REG_STAT:  nxt_rdata = {14'h0000, ill_sticky_ff, ~op_ready_o};
            default:   nxt_rdata = 16'h0000;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rdata_ff <= 16'h0000;
        end else if (reg_rd_i) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= 16'h0000;
        end
    end

    assign reg_rdata_o = rdata_ff;

endmodule

// >>> ctt_exec_asserts.sv
// Port-level checks for the execution unit.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module ctt_exec_asserts
    import ctt_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    input wire logic              sys_clk_i,
    input wire logic              rst_i,
    input wire logic              op_valid_i,
    input wire ctt_req_t          op_req_i,
    input wire logic              op_ready_o,
    input wire logic              op_done_o,
    input wire logic              op_illegal_o,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [15:0]       reg_wdata_i,
    input wire logic              reg_wr_i,
    input wire logic              reg_rd_i,
    input wire logic [15:0]       reg_rdata_o
);
    // Instruction length by opcode, zero for an unknown one
    function automatic int len(input logic [15:0] op);
        case (op)
            OPC_LDWED, OPC_LDWE, OPC_DFLG: len = 4;
            OPC_TST_X8, OPC_TST_Y8, OPC_TST_Z8, OPC_TST_X16, OPC_TST_Y16, OPC_TST_Z16,
            OPC_TST_EXT, OPC_WIDX, OPC_WER: len = 6;
            OPC_TEST_ACC_A_OP, OPC_TEST_ACC_B_OP, OPC_TEST_ACC_D_OP, OPC_TEST_ACC_E_OP, OPC_WET, OPC_DMSK, OPC_EXTB,
            OPC_SEXTB, OPC_BXK, OPC_BYK, OPC_BZK, OPC_BSK, OPC_DE, OPC_ED, OPC_FLGA,
            OPC_FLGD: len = 2;
            default: len = 0;
        endcase
    endfunction
    int n;
    // Accepted instruction and its length
    wire logic acc = op_valid_i && op_ready_o;
    assign n = len(op_req_i.opcode);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    a_short_done: assert property (acc && n <= 2 |=> op_done_o)
        else $error("short op late");
    a_four_cycle: assert property (acc && n == 4 |=> !op_done_o ##1 !op_done_o ##1 op_done_o)
        else $error("4-cycle timing");
    a_six_cycle: assert property (acc && n == 6 |=> (!op_done_o && !op_ready_o)[*4] ##1 op_done_o)
        else $error("6-cycle timing");
    a_busy_refuse: assert property (acc |=> !op_ready_o)
        else $error("ready while busy");
    a_ready_back: assert property (op_done_o |=> op_ready_o && !op_done_o)
        else $error("not idle after done");
    a_illegal_set: assert property (acc && n == 0 |=> op_illegal_o)
        else $error("unknown op unflagged");
    a_illegal_clear: assert property (acc && n != 0 |=> !op_illegal_o)
        else $error("illegal flag stuck");
    a_illegal_hold: assert property (!acc |=> $stable(op_illegal_o))
        else $error("illegal flag moved");
    a_read_zero: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
        else $error("stray read data");
    // Main scenarios reached
    c_six_cycle: cover property (acc && n == 6);
    c_unknown: cover property (acc && n == 0);
    c_read: cover property (reg_rd_i ##1 reg_rdata_o != 16'h0000);
endmodule

bind ctt_exec ctt_exec_asserts #(.ADDR_W(ADDR_W)) u_asserts (
    .sys_clk_i, .rst_i, .op_valid_i, .op_req_i, .op_ready_o, .op_done_o, .op_illegal_o,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o);

// >>> testbench.sv
// Self-checking bench for the execution unit.
// Assumes the checker file binds itself.
`timescale 1ns/10ps
module testbench
    import ctt_pkg::*;
;
    logic        sys_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        op_valid_i = 1'b0;
    ctt_req_t    op_req_i = '0;
    logic        op_ready_o, op_done_o, op_illegal_o;
    logic [3:0]  reg_addr_i = '0;
    logic [15:0] reg_wdata_i = '0;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [15:0] reg_rdata_o;
    logic [15:0] m [16] = '{default: '0};
    int          fail_count = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    localparam logic [15:0] op_list [29] = '{OPC_TST_X8, OPC_TST_Y8, OPC_TST_Z8,
        OPC_TST_X16, OPC_TST_Y16, OPC_TST_Z16, OPC_TST_EXT, OPC_TEST_ACC_A_OP, OPC_TEST_ACC_B_OP, OPC_TEST_ACC_D_OP,
        OPC_TEST_ACC_E_OP, OPC_LDWED, OPC_LDWE, OPC_WIDX, OPC_WER, OPC_WET, OPC_DMSK, OPC_EXTB,
        OPC_SEXTB, OPC_BXK, OPC_BYK, OPC_BZK, OPC_BSK, OPC_DE, OPC_ED, OPC_FLGA,
        OPC_FLGD, OPC_DFLG, 16'hffff};

    ctt_exec uut (.sys_clk_i, .rst_i, .op_valid_i, .op_req_i, .op_ready_o, .op_done_o,
        .op_illegal_o, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o);

    // Clock and hang guard
    always #2 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            fail_count++;
            results();
        end
    end

    task automatic results();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t reg %h got %h exp %h", $time, reg_addr_i, got, exp);
        end
    endtask

    task automatic cmp_cyc(input int got, input int exp);
        samples_checked++;
        if (got != exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t cycles got %0d exp %0d", $time, got, exp);
        end
    endtask

    // Mostly random words, zero one time in four
    function automatic logic [15:0] rnd16();
        rnd16 = ($urandom % 4 == 0) ? '0 : 16'($urandom);
    endfunction

    // Flag update, vc clears V and C; a byte sits in the upper half
    function automatic void nz(input logic [15:0] w, input logic [1:0] vc);
        m[3][CCR_N] = w[15];
        m[3][CCR_Z] = ~|w;
        if (vc[1]) m[3][CCR_V] = 1'b0;
        if (vc[0]) m[3][CCR_C] = 1'b0;
    endfunction

    // Register write, mirrored in the model
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        @(posedge sys_clk_i);
        if (a == REG_STAT) m[10][1] &= ~d[1];
        else if (a == REG_AM_HI || a == REG_EK) m[a] = {12'h000, d[3:0]};
        else if (a < REG_STAT) m[a] = d;
    endtask

    // Register read, checked in the slot after the strobe
    task automatic rd_chk(input logic [3:0] a);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge sys_clk_i);
        cmp(reg_rdata_o, m[a]);
        @(posedge sys_clk_i);
    endtask

    // Reference model of one op; returns its length
    task automatic exec_model(input logic [15:0] op, input logic [15:0] opnd, output int n);
        logic [35:0] am, t;
        logic [15:0] w;
        am = {m[6][3:0], m[5], m[4]};
        t = am + 36'h8000;
        n = 2;
        case (op)
            OPC_TST_X8, OPC_TST_Y8, OPC_TST_Z8, OPC_TST_X16, OPC_TST_Y16, OPC_TST_Z16,
            OPC_TST_EXT: begin
                n = 6;
                nz({opnd[7:0], 8'h00}, 2'b11);
            end
            OPC_TEST_ACC_A_OP: nz({m[0][15:8], 8'h00}, 2'b11);
            OPC_TEST_ACC_B_OP: nz({m[0][7:0], 8'h00}, 2'b11);
            OPC_TEST_ACC_D_OP: nz(m[0], 2'b11);
            OPC_TEST_ACC_E_OP: nz(m[1], 2'b11);
            OPC_LDWED, OPC_LDWE: begin
                n = 4;
                am = {{4{m[1][15]}}, m[1], (op == OPC_LDWED) ? m[0] : 16'h0000};
                {m[6], m[5], m[4]} = {12'h000, am};
                {m[3][CCR_MV], m[3][CCR_EV]} = 2'b00;
            end
            OPC_WER, OPC_WET: begin
                if (op == OPC_WER) begin
                    n = 6;
                    m[3][CCR_MV] = !am[35] && t[35];
                    m[3][CCR_EV] = t[35:31] != {5{t[31]}};
                end
                w = (op == OPC_WER) ? t[31:16] : am[31:16];
                if (m[3][CCR_SM] && (m[3][CCR_MV] || m[3][CCR_EV])) w = am[35] ? SAT_NEG : SAT_POS;
                m[1] = w;
                nz(w, 2'b00);
            end
            OPC_WIDX: begin
                n = 6;
                {m[2], m[1], m[0]} = {{12{am[35]}}, am};
            end
            OPC_DMSK: m[9] = m[0];
            OPC_EXTB: m[0][7:0] = {4'h0, m[8][3:0]};
            OPC_SEXTB: m[0][7:0] = {4'h0, m[7][15:12]};
            OPC_BSK: m[7][15:12] = m[0][3:0];
            OPC_BZK: m[7][11:8] = m[0][3:0];
            OPC_BYK: m[7][7:4] = m[0][3:0];
            OPC_BXK: m[7][3:0] = m[0][3:0];
            OPC_DE: begin
                m[1] = m[0];
                nz(m[0], 2'b10);
            end
            OPC_ED: begin
                m[0] = m[1];
                nz(m[1], 2'b10);
            end
            OPC_FLGA: m[0][15:8] = m[3][15:8];
            OPC_FLGD: m[0] = m[3];
            OPC_DFLG: begin
                n = 4;
                m[3][15:4] = m[0][15:4];
            end
            default: m[10][1] = 1'b1;
        endcase
    endtask

    // Issue one op, write while busy, count its cycles
    task automatic run_op(input logic [15:0] op, input logic [15:0] opnd);
        int   n = 0, exp_n;
        logic dn = 1'b0;
        op_valid_i <= 1'b1;
        op_req_i <= {op, opnd};
        @(posedge sys_clk_i);
        op_valid_i <= 1'b0;
        reg_wr_i <= 1'b1;
        reg_addr_i <= REG_D;
        reg_wdata_i <= ~m[0];
        exec_model(op, opnd, exp_n);
        while (!dn && n < 8) begin
            @(negedge sys_clk_i);
            n++;
            dn = (op_done_o === 1'b1);
            cmp(16'(op_illegal_o), 16'(op == 16'hffff));
            @(posedge sys_clk_i);
            reg_wr_i <= 1'b0;
        end
        cmp_cyc(n + 1, exp_n);
    endtask

    // Reset values, then random state and every opcode
    initial begin
        void'($urandom(32'h6d0430ee));
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        for (int a = 0; a < 16; a++) rd_chk(a[3:0]);
        for (int k = 0; k < 250; k++) begin
            for (int a = 0; a < 10; a++) wr(a[3:0], rnd16());
            wr(4'(11 + $urandom % 5), rnd16());
            if (k % 8 == 0) wr(REG_STAT, 16'h0002);
            run_op(op_list[k < 29 ? k : $urandom % 29], rnd16());
            for (int a = 0; a < 16; a++) rd_chk(a[3:0]);
        end
        results();
    end
endmodule
